// ===== kef_pkg.sv
// Constants, types and mode codes for the key entry formatter.
// Assumes a single 25 MHz system clock domain; no other clocking.
package kef_pkg;

   // Input modes
   typedef enum logic [1:0] {KEF_KEYBOARD, KEF_SENSOR, KEF_STROBED}
      kef_mode_e;

   // Character word field positions
   localparam int KEF_CTRL_BIT = 7;
   localparam int KEF_SHIFT_BIT = 6;
   localparam int KEF_ROW_LSB = 3;
   localparam int KEF_COL_LSB = 0;

   // Display command fields
   localparam int KEF_CMD_AI_BIT = 4;
   localparam int KEF_CMD_ADDR_LSB = 0;

   // Sizes
   localparam int KEF_DIGITS_WIDE = 16;
   localparam int KEF_DIGITS_NARROW = 8;
   localparam int KEF_SENSOR_ROWS = 8;
   localparam int KEF_FIFO_DEPTH = 8;

   // Scan step rate: one scan row per 100 us
   localparam int KEF_CLK_HZ = 25000000;
   localparam int KEF_SCAN_STEP_US = 100;
   localparam int KEF_SCAN_DIV =
      KEF_CLK_HZ / 1000000 * KEF_SCAN_STEP_US;

   // Register offsets (word addresses)
   localparam logic [3:0] KEF_REG_CTRL = 4'h0;
   localparam logic [3:0] KEF_REG_STAT = 4'h1;
   localparam logic [3:0] KEF_REG_MASK = 4'h2;
   localparam logic [3:0] KEF_REG_DCMD = 4'h3;
   localparam logic [3:0] KEF_REG_DDATA = 4'h4;
   localparam logic [3:0] KEF_REG_FIFO = 4'h5;
   localparam logic [3:0] KEF_REG_SENS = 4'h6;
   localparam logic [3:0] KEF_REG_LEVEL = 4'h7;

   // Control register fields and reset value
   localparam int KEF_CTRL_MODE_LSB = 0;
   localparam int KEF_CTRL_RIGHT_BIT = 2;
   localparam int KEF_CTRL_NARROW_BIT = 3;
   localparam logic [7:0] KEF_CTRL_RESET = 8'h00;

   // Interrupt status bits
   localparam int KEF_IRQ_FIFO = 0;
   localparam int KEF_IRQ_OVER = 1;
   localparam int KEF_IRQ_SCAN = 2;
   localparam logic [2:0] KEF_MASK_RESET = 3'h0;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } kef_bus_s;

   // Key detection event from the outside scanner
   typedef struct packed {
      logic valid;
      logic [2:0] row;
      logic [2:0] col;
   } kef_key_s;

endpackage

// ===== kef_sync.sv
// Two-flop synchroniser for a bundle of pin levels.
// Assumes the inputs are asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module kef_sync
#(
   parameter int WIDTH = 11
)
(
   input wire logic clk_sys, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic [WIDTH-1:0] pinIn, // Raw pin levels
   output logic [WIDTH-1:0] pinSync // Synchronised levels
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         meta_q <= '0;
         pinSync <= '0;
      end
      else
      begin
         meta_q <= pinIn;
         pinSync <= meta_q;
      end
   end

endmodule
`default_nettype wire

// ===== kef_format.sv
// Key entry formatter: FIFO and sensor words, display RAM fill order.
// Assumes key validation is done outside and arrives as a key event.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module kef_format
   import kef_pkg::*;
#(
   parameter int SCAN_DIV = KEF_SCAN_DIV
)
(
   input wire logic clk_sys, // System clock
   input wire logic resetn, // Async reset, active low
   input wire logic [3:0] busAddr, // Register word address
   input wire logic [7:0] busWdata, // Write data
   input wire logic busWr, // Write strobe
   input wire logic busRd, // Read strobe
   output logic [7:0] busRdata, // Read data, cycle after strobe
   input wire logic [7:0] return_lines, // Return line pins
   input wire logic control_strobe_input, // Control key or strobe pin
   input wire logic shiftKeyInput, // Shift key pin
   input wire kef_key_s keyEvent, // Validated key hit
   output logic [2:0] scan_lines, // Current scan row
   output logic [3:0] digitSel, // Digit being driven
   output logic [7:0] digitData, // Character for that digit
   output logic irq // Interrupt, level
);

   ////////////////////////////////////////////////////////////////
   // Pin synchroniser
   logic [9:0] pinSync;
   logic [7:0] retSync;
   logic strobeSync;
   logic shiftSync;

   kef_sync #(.WIDTH(10)) u_sync
   (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .pinIn({shiftKeyInput, control_strobe_input, return_lines}),
      .pinSync(pinSync)
   );

   assign retSync = pinSync[7:0];
   assign strobeSync = pinSync[8];
   assign shiftSync = pinSync[9];

   ////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic [7:0] ctrl;
      logic [2:0] stat;
      logic [2:0] mask;
      logic aiFlag;
      logic [3:0] dispAddr;
      logic [3:0] entryCount;
      logic [15:0][7:0] dispRam;
      logic [7:0][7:0] sensRam;
      logic [7:0][7:0] fifo;
      logic [2:0] rdPtr;
      logic [2:0] wrPtr;
      logic [3:0] level;
      logic [2:0] scanRow;
      logic [15:0] divCnt;
      logic [3:0] digit;
      logic strobePrev;
      logic [7:0] rdata;
      logic [2:0] scanOut;
      logic [3:0] digitOut;
      logic [7:0] digitDat;
      logic irq;
   } kef_state_s;

   kef_state_s s_q;
   kef_state_s s_d;

   kef_mode_e mode;
   logic rightEntry;
   logic narrow;
   logic [3:0] lastAddr;
   logic [3:0] rawAddr;
   logic [3:0] dataAddr;
   logic stepTick;

   // Decoded control fields
   always_comb
   begin
      unique case (s_q.ctrl[KEF_CTRL_MODE_LSB +: 2])
         2'h1: mode = KEF_SENSOR;
         2'h2: mode = KEF_STROBED;
         default: mode = KEF_KEYBOARD;
      endcase
   end

   assign rightEntry = s_q.ctrl[KEF_CTRL_RIGHT_BIT];
   assign narrow = s_q.ctrl[KEF_CTRL_NARROW_BIT];
   assign lastAddr = narrow ? 4'(KEF_DIGITS_NARROW - 1)
                            : 4'(KEF_DIGITS_WIDE - 1);
   assign stepTick = (s_q.divCnt == 16'(SCAN_DIV - 1));
   // Narrow display only uses the low three address bits
   assign rawAddr = narrow ? {1'b0, s_q.dispAddr[2:0]} : s_q.dispAddr;
   // Right entry stores each character at the next rotating slot, so
   // the slot-to-digit map shifts as entries go in
   assign dataAddr = rightEntry ? s_q.entryCount : rawAddr;

   ////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      logic [7:0] word;
      logic push;
      logic [3:0] slot;
      logic [3:0] rel;
      logic scanDone;
      word = 8'h00;
      push = 1'b0;
      slot = 4'h0;
      rel = 4'h0;
      scanDone = 1'b0;
      s_d = s_q;
      s_d.strobePrev = strobeSync;

      // Scan step divider and row counter
      s_d.divCnt = stepTick ? 16'h0000 : s_q.divCnt + 16'h0001;
      if (stepTick)
      begin
         s_d.scanRow = s_q.scanRow + 3'h1;
         s_d.digit = (s_q.digit == lastAddr) ? 4'h0
                                             : s_q.digit + 4'h1;
      end

      // Sensor rows rewritten each step regardless of change
      if (mode == KEF_SENSOR && stepTick)
      begin
         s_d.sensRam[s_q.scanRow] = retSync;
         if (s_q.scanRow == 3'h7)
            scanDone = 1'b1;
      end

      // Keyboard word assembly
      if (mode == KEF_KEYBOARD && keyEvent.valid)
      begin
         word[KEF_CTRL_BIT] = strobeSync;
         word[KEF_SHIFT_BIT] = shiftSync;
         word[KEF_ROW_LSB +: 3] = keyEvent.row;
         word[KEF_COL_LSB +: 3] = keyEvent.col;
         push = 1'b1;
      end
      // Strobed word on rising strobe edge
      if (mode == KEF_STROBED && strobeSync && !s_q.strobePrev)
      begin
         word = retSync;
         push = 1'b1;
      end

      // Bus reads
      s_d.rdata = 8'h00;
      if (busRd)
      begin
         unique case (busAddr)
            KEF_REG_CTRL: s_d.rdata = s_q.ctrl;
            KEF_REG_STAT: s_d.rdata = {5'h00, s_q.stat};
            KEF_REG_MASK: s_d.rdata = {5'h00, s_q.mask};
            KEF_REG_DCMD: s_d.rdata = {3'h0, s_q.aiFlag, s_q.dispAddr};
            KEF_REG_DDATA:
            begin
               s_d.rdata = s_q.dispRam[dataAddr];
               if (s_q.aiFlag)
                  s_d.dispAddr = s_q.dispAddr + 4'h1;
            end
            KEF_REG_FIFO:
            begin
               s_d.rdata = s_q.fifo[s_q.rdPtr];
               if (s_q.level != 4'h0)
               begin
                  s_d.rdPtr = s_q.rdPtr + 3'h1;
                  s_d.level = s_q.level - 4'h1;
               end
            end
            KEF_REG_SENS: s_d.rdata = s_q.sensRam[s_q.scanRow];
            KEF_REG_LEVEL: s_d.rdata = {4'h0, s_q.level};
            default: s_d.rdata = 8'h00;
         endcase
      end

      // Bus writes
      if (busWr)
      begin
         unique case (busAddr)
            KEF_REG_CTRL:
            begin
               s_d.ctrl = busWdata;
               s_d.entryCount = 4'h0;
            end
            KEF_REG_STAT: s_d.stat = s_q.stat & ~busWdata[2:0];
            KEF_REG_MASK: s_d.mask = busWdata[2:0];
            KEF_REG_DCMD:
            begin
               s_d.aiFlag = busWdata[KEF_CMD_AI_BIT];
               s_d.dispAddr = busWdata[KEF_CMD_ADDR_LSB +: 4];
            end
            KEF_REG_DDATA:
            begin
               s_d.dispRam[dataAddr] = busWdata;
               // Wrap keeps the next write on the first digit
               if (s_q.aiFlag)
                  s_d.dispAddr = (rawAddr == lastAddr) ? 4'h0
                     : s_q.dispAddr + 4'h1;
               if (rightEntry)
                  s_d.entryCount = (s_q.entryCount == lastAddr) ? 4'h0
                     : s_q.entryCount + 4'h1;
            end
            default: ;
         endcase
      end

      // Scan-done set applied after the bus clear, so the event wins
      if (scanDone)
         s_d.stat[KEF_IRQ_SCAN] = 1'b1;

      // FIFO push; a full FIFO drops the word and flags overrun
      if (push)
      begin
         if (s_d.level == 4'(KEF_FIFO_DEPTH))
            s_d.stat[KEF_IRQ_OVER] = 1'b1;
         else
         begin
            s_d.fifo[s_q.wrPtr] = word;
            s_d.wrPtr = s_q.wrPtr + 3'h1;
            s_d.level = s_d.level + 4'h1;
            s_d.stat[KEF_IRQ_FIFO] = 1'b1;
         end
      end

      // Digit refresh: left entry maps address straight to digit
      if (rightEntry)
      begin
         // Newest entry sits rightmost, older ones to its left
         rel = lastAddr - s_q.digit;
         slot = s_q.entryCount - 4'h1 - rel;
         if (narrow)
            slot = {1'b0, slot[2:0]};
      end
      else
         slot = s_q.digit;
      s_d.scanOut = s_q.scanRow;
      s_d.digitOut = s_q.digit;
      s_d.digitDat = s_q.dispRam[slot];
      s_d.irq = |(s_d.stat & s_d.mask);
   end

   ////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         s_q <= '0;
         s_q.ctrl <= KEF_CTRL_RESET;
         s_q.mask <= KEF_MASK_RESET;
      end
      else
         s_q <= s_d;
   end

   // Outputs straight from the state register
   assign busRdata = s_q.rdata;
   assign scan_lines = s_q.scanOut;
   assign digitSel = s_q.digitOut;
   assign digitData = s_q.digitDat;
   assign irq = s_q.irq;

endmodule
`default_nettype wire

// ===== kef_format_chk.sv
// Checker for kef_format: scan, bus and interrupt timing.
// Assumes SCAN_DIV of 4; sees only the top ports.
`timescale 1ns/1ps
`default_nettype none
module kef_format_chk
   import kef_pkg::*;
#(
   parameter int SCAN_DIV = 4
)
(
   input wire logic clk_sys, // Clock
   input wire logic resetn, // Reset
   input wire logic [3:0] busAddr, // Address
   input wire logic [7:0] busWdata, // Write data
   input wire logic busWr, // Write
   input wire logic busRd, // Read
   input wire logic [7:0] busRdata, // Read data
   input wire logic control_strobe_input, // Strobe
   input wire kef_key_s keyEvent, // Key hit
   input wire logic [2:0] scan_lines, // Scan row
   input wire logic irq // Interrupt
);
////////////////////////////////////////
   // Mode and mask shadows, since both live inside the block
   logic [1:0] mode_q;
   logic [2:0] mask_q;
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         mode_q <= 2'h0;
         mask_q <= 3'h0;
      end
      else if (busWr && busAddr == KEF_REG_CTRL)
         mode_q <= busWdata[1:0];
      else if (busWr && busAddr == KEF_REG_MASK)
         mask_q <= busWdata[2:0];
   end
////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_scan_order: assert property (
      $changed(scan_lines) |-> scan_lines == $past(scan_lines) + 3'h1)
      else $error("scan row skipped");
   a_scan_hold: assert property (
      $changed(scan_lines) |=> $stable(scan_lines)[*3])
      else $error("scan row too short");
   a_scan_move: assert property (
      $changed(scan_lines) |-> ##4 $changed(scan_lines))
      else $error("scan row stuck");
   a_key_irq: assert property (
      keyEvent.valid && mode_q == 2'h0 && mask_q[0] |-> ##[1:3] irq)
      else $error("key word raised no interrupt");
   a_strobe_irq: assert property (
      $rose(control_strobe_input) && mode_q == 2'h2 && mask_q[0]
      |-> ##[2:7] irq)
      else $error("strobe raised no interrupt");
   a_sensor_quiet: assert property (
      keyEvent.valid && mode_q == 2'h1 && mask_q == 3'h1 && !irq
      |=> !irq[*3])
      else $error("sensor mode took a key");
   a_mask_off: assert property (
      busWr && busAddr == KEF_REG_MASK && busWdata == 8'h00
      |-> ##[1:2] !irq)
      else $error("masked interrupt still high");
   a_rdata_idle: assert property (!busRd |=> busRdata == 8'h00)
      else $error("read data outside read slot");
   cover property (keyEvent.valid && mode_q == 2'h0);
   cover property ($rose(control_strobe_input) && mode_q == 2'h2);
   cover property ($fell(irq));
endmodule
bind kef_format kef_format_chk #(.SCAN_DIV(SCAN_DIV)) i_chk (
   .clk_sys(clk_sys), .resetn(resetn), .busAddr(busAddr),
   .busWdata(busWdata), .busWr(busWr), .busRd(busRd),
   .busRdata(busRdata), .control_strobe_input(control_strobe_input),
   .keyEvent(keyEvent), .scan_lines(scan_lines), .irq(irq));
`default_nettype wire

// ===== kef_matrix_model.sv
// Key matrix and parallel strobe source on the return lines.
// Assumes one key at a time; pull-ups keep idle lines high.
`timescale 1ns/1ps
`default_nettype none
module kef_matrix_model
(
   input wire logic [2:0] scan_lines, // Row scanned
   input wire logic keyDown, // Key held
   input wire logic [2:0] keyRow, // Key row
   input wire logic [2:0] keyCol, // Key column
   input wire logic strobeOn, // Parallel source on
   input wire logic [7:0] strobeData, // Parallel word
   output logic [7:0] return_lines // Return pins
);
   // Released lines float to the pull-up level
   always_comb
   begin
      return_lines = 8'hFF;
      if (strobeOn)
         return_lines = strobeData;
      else if (keyDown && scan_lines == keyRow)
         return_lines[keyCol] = 1'b0;
   end
endmodule
`default_nettype wire

// ===== key_entry_format_display_fill_tb.sv
// Self-checking bench for the key entry formatter.
// Assumes SCAN_DIV of 4 and the matrix model on the pins.
`timescale 1ns/1ps
`default_nettype none
module key_entry_format_display_fill_tb
   import kef_pkg::*;
;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] busAddr = 4'h0;
   logic [7:0] busWdata = 8'h00;
   logic busWr = 1'b0;
   logic busRd = 1'b0;
   logic [7:0] busRdata;
   logic [7:0] return_lines;
   logic control_strobe_input = 1'b0;
   logic shiftKeyInput = 1'b1;
   kef_key_s keyEvent = '0;
   logic [2:0] scan_lines;
   logic [3:0] digitSel;
   logic [7:0] digitData;
   logic irq;
   logic strobeOn = 1'b0;
   logic [7:0] strobeData = 8'h00;
   int err_total = 0;
   int comparisons = 0;
   // Clock of 40 ns
   always #20 clk_sys = ~clk_sys;
   kef_format #(.SCAN_DIV(4)) i_dut (.clk_sys(clk_sys),
      .resetn(resetn), .busAddr(busAddr), .busWdata(busWdata),
      .busWr(busWr), .busRd(busRd), .busRdata(busRdata),
      .return_lines(return_lines), .shiftKeyInput(shiftKeyInput),
      .control_strobe_input(control_strobe_input),
      .keyEvent(keyEvent), .scan_lines(scan_lines),
      .digitSel(digitSel), .digitData(digitData), .irq(irq));
   kef_matrix_model i_model (.scan_lines(scan_lines),
      .keyDown(keyEvent.valid), .keyRow(keyEvent.row),
      .keyCol(keyEvent.col), .strobeOn(strobeOn),
      .strobeData(strobeData), .return_lines(return_lines));
////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      busWr <= 1'b1;
      busAddr <= a;
      busWdata <= d;
      @(posedge clk_sys);
      busWr <= 1'b0;
   endtask
   // Data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      busRd <= 1'b1;
      busAddr <= a;
      @(posedge clk_sys);
      busRd <= 1'b0;
      #1 chk(busRdata, e);
   endtask
   task automatic hit(input logic [6:0] k);
      repeat (4) @(posedge clk_sys);
      keyEvent <= {1'b1, k[5:0]};
      @(posedge clk_sys);
      keyEvent <= '0;
      repeat (3) @(posedge clk_sys);
   endtask
   // Waits for a digit on the refresh scan
   task automatic dig(input logic [3:0] d, input logic [7:0] e);
      // Refresh data lag the RAM write by one clock
      @(posedge clk_sys);
      repeat (300)
      begin
         @(negedge clk_sys);
         if (digitSel === d)
            break;
      end
      chk(digitData, e);
   endtask
////////////////////////////////////////
   task automatic t_key;
      wr(KEF_REG_MASK, 8'h01);
      control_strobe_input <= 1'b1;
      shiftKeyInput <= 1'b0;
      hit(7'h2A);
      chk({7'h00, irq}, 8'h01);
      control_strobe_input <= 1'b0;
      shiftKeyInput <= 1'b1;
      hit(7'h07);
      rd(KEF_REG_LEVEL, 8'h02);
      rd(KEF_REG_FIFO, 8'hAA);
      rd(KEF_REG_FIFO, 8'h47);
      rd(4'hF, 8'h00);
      wr(KEF_REG_STAT, 8'h01);
      repeat (3) @(posedge clk_sys);
      chk({7'h00, irq}, 8'h00);
      $display("t_key done");
   endtask
   // Nine keys into an eight-deep FIFO: the last one is dropped
   task automatic t_overrun;
      for (int i = 0; i < 9; i++)
         hit(7'(i));
      rd(KEF_REG_LEVEL, 8'h08);
      rd(KEF_REG_STAT, 8'h03);
      for (int i = 0; i < 8; i++)
         rd(KEF_REG_FIFO, 8'h40 | 8'(i));
      rd(KEF_REG_LEVEL, 8'h00);
      wr(KEF_REG_STAT, 8'h03);
      $display("t_overrun done");
   endtask
   task automatic t_strobe;
      wr(KEF_REG_CTRL, 8'h02);
      strobeOn <= 1'b1;
      for (int i = 0; i < 2; i++)
      begin
         strobeData <= 8'h5C ^ {8{i[0]}};
         repeat (4) @(posedge clk_sys);
         control_strobe_input <= 1'b1;
         repeat (8) @(posedge clk_sys);
         control_strobe_input <= 1'b0;
      end
      chk({7'h00, irq}, 8'h01);
      rd(KEF_REG_FIFO, 8'h5C);
      rd(KEF_REG_FIFO, 8'hA3);
      wr(KEF_REG_STAT, 8'h07);
      strobeOn <= 1'b0;
      $display("t_strobe done");
   endtask
   task automatic t_sensor;
      wr(KEF_REG_CTRL, 8'h01);
      control_strobe_input <= 1'b1;
      hit(7'h11);
      chk({7'h00, irq}, 8'h00);
      rd(KEF_REG_LEVEL, 8'h00);
      @(posedge clk_sys);
      strobeOn <= 1'b1;
      strobeData <= 8'h3C;
      repeat (40) @(posedge clk_sys);
      rd(KEF_REG_SENS, 8'h3C);
      @(posedge clk_sys);
      strobeData <= 8'hC3;
      repeat (40) @(posedge clk_sys);
      rd(KEF_REG_SENS, 8'hC3);
      @(posedge clk_sys);
      strobeOn <= 1'b0;
      // Scan-done status is set by now; unmask it, then mask all
      wr(KEF_REG_MASK, 8'h04);
      repeat (2) @(posedge clk_sys);
      chk({7'h00, irq}, 8'h01);
      wr(KEF_REG_MASK, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk({7'h00, irq}, 8'h00);
      $display("t_sensor done");
   endtask
   task automatic t_disp;
      wr(KEF_REG_CTRL, 8'h08);
      wr(KEF_REG_DCMD, 8'h10);
      for (int i = 1; i < 10; i++)
         wr(KEF_REG_DDATA, 8'(i));
      dig(4'h0, 8'h09);
      dig(4'h1, 8'h02);
      dig(4'h7, 8'h08);
      rd(KEF_REG_DCMD, 8'h11);
      wr(KEF_REG_DCMD, 8'h10);
      rd(KEF_REG_DDATA, 8'h09);
      rd(KEF_REG_DDATA, 8'h02);
      rd(KEF_REG_DCMD, 8'h12);
      wr(KEF_REG_CTRL, 8'h0C);
      wr(KEF_REG_DCMD, 8'h10);
      wr(KEF_REG_DDATA, 8'hA1);
      dig(4'h7, 8'hA1);
      wr(KEF_REG_DDATA, 8'hA2);
      wr(KEF_REG_DDATA, 8'hA3);
      dig(4'h7, 8'hA3);
      dig(4'h6, 8'hA2);
      dig(4'h5, 8'hA1);
      wr(KEF_REG_MASK, 8'h00);
      $display("t_disp done");
   endtask
   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Tests need some 500 cycles
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      err_total++;
      results();
   end
   initial
   begin
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      t_key();
      t_overrun();
      t_strobe();
      t_sensor();
      t_disp();
      results();
   end
endmodule
`default_nettype wire
